/* inc/swli_defs.svh */
`ifndef SWLI_DEFS_SVH
`define SWLI_DEFS_SVH

// Serial word layout: three channel-select bits then eight setting bits
`define SWLI_WORD_BITS   11
`define SWLI_DATA_BITS   8
`define SWLI_ADDR_BITS   3
`define SWLI_ADDR_LSB    8
`define SWLI_DATA_LSB    0

// Channel counts: four-channel default, six-channel variant
`define SWLI_NUM_CH      4
`define SWLI_MAX_CH      6

// Wiper centred value for presets and power-on
`define SWLI_MIDSCALE    8'h80

// Synchroniser depth
`define SWLI_SYNC_STAGES 2

`endif

/* inc/swli_pkg.sv */
`include "swli_defs.svh"

package swli_pkg;

  // Frame tracking in the system clock domain
  typedef enum logic [1:0] {
    SWLI_IDLE,
    SWLI_FRAME,
    SWLI_LOAD
  } swli_state_type;

  // One wiper setting latch
  typedef logic [`SWLI_DATA_BITS-1:0] swli_wiper_type;

  // One captured serial word
  typedef logic [`SWLI_WORD_BITS-1:0] swli_word_type;

endpackage

/* inc/swli_link_if.sv */
`timescale 1ns/1ps
`include "swli_defs.svh"

// Signals shared between the link-side shifter and the control logic
interface swli_link_if;
  logic                  chipSelectN;  // Frame select, low active
  logic                  serialDataIn; // Serial data from host
  swli_pkg::swli_word_type shiftWord;  // Shift register contents
  logic                  sdoBit;       // Bit pushed out of the register

  // Shifter side
  modport shift (
    input  chipSelectN,
    input  serialDataIn,
    output shiftWord,
    output sdoBit
  );

  // Control side
  modport ctrl (
    output chipSelectN,
    output serialDataIn,
    input  shiftWord,
    input  sdoBit
  );
endinterface

/* rtl/swli_sync.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Two-flop level synchroniser, one lane per bit
module swli_sync #(
  parameter int                WIDTH   = 1,
  parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_ff;  // Metastable stage, read only by stage2
  logic [WIDTH-1:0] stage2_ff;  // Settled stage

  // Refuse a zero-width instance
  if (WIDTH < 1) begin : gWidthCheck
    $error("swli_sync: WIDTH must be at least one");
  end

  // Both stages reset to the idle level of the lane
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage1_ff <= RST_VAL;
      stage2_ff <= RST_VAL;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;

endmodule

/* rtl/swli_shifter.sv */
`timescale 1ns/1ps
`include "swli_defs.svh"

////////////////////////////////////////////////////////////////////////
// Link-side shift register, clocked by the host serial clock
module swli_shifter (
  input  wire logic serialClk,
  swli_link_if.shift link
);

  swli_pkg::swli_word_type shift_ff;  // Serial shift register
  logic                    sdo_ff;    // Bit displaced by the last shift

  // Shift on rising serial clock while selected; between rising edges
  // nothing moves, so a low clock leaves the register untouched.
  // No reset here: the serial clock only runs inside frames, so the
  // contents are undefined until eleven bits have been clocked in.
  always_ff @(posedge serialClk) begin
    if (!link.chipSelectN) begin
      shift_ff <= {shift_ff[`SWLI_WORD_BITS-2:0], link.serialDataIn};
      sdo_ff   <= shift_ff[`SWLI_WORD_BITS-1];
    end
  end

  // Word is static while deselected, so the control side may sample it
  assign link.shiftWord = shift_ff;
  assign link.sdoBit    = sdo_ff;

endmodule

/* rtl/swli_top.sv */
// Behaviour
// - Selected rising clock shifts; old bit leaves
// - Low clock: register still, output enabled
// - Select rise captures last eleven bits
// - Select rise strobes at most one channel
// - Addresses 0-3, plus 4-5 on six
// - Low eight bits load; others keep
// - Preset low: all midscale, output cleared
// - Preset rise, deselected: all load 80h
// - Power-down, preset high: open A, wiper to B
// - Power-down releases serial output line unless preset low
// - Serial output pulls low, releases high
// - Word: three address, eight data, MSB-first
// - Reset presets every latch to midscale
// - Power-down keeps latch contents
`timescale 1ns/1ps
`include "swli_defs.svh"

module swli_top #(
  parameter int NUM_CH = `SWLI_NUM_CH  // Four or six channels
) (
  input  wire logic                                  clk,
  input  wire logic                                  resetn,
  input  wire logic                                  serialClk,
  input  wire logic                                  chipSelectN,
  input  wire logic                                  serialDataIn,
  input  wire logic                                  midscalePresetN,
  input  wire logic                                  powerDownN,
  input  wire logic                                  serialDataOutIn,
  output logic                                       serialDataOut_ff,
  output logic                                       serialDataOutOe_ff,
  output logic                                       serialOutLevel_ff,
  output logic [NUM_CH*`SWLI_DATA_BITS-1:0]          wiperSetting_ff,
  output logic [NUM_CH-1:0]                          channelLoad_ff,
  output logic                                       wordDropped_ff,
  output logic                                       aTerminalOpen_ff,
  output logic                                       wiperToB_ff
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Only the four- and six-channel variants exist
  if (NUM_CH != `SWLI_NUM_CH && NUM_CH != `SWLI_MAX_CH) begin : gChCheck
    $error("swli_top: NUM_CH must be four or six");
  end

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam int SYNC_W = 5;  // Lanes crossing into the clk domain

  // Lane order of the synchroniser vector
  localparam int LANE_PD  = 0;
  localparam int LANE_PR  = 1;
  localparam int LANE_CS  = 2;
  localparam int LANE_SDO = 3;
  localparam int LANE_PIN = 4;

  // Idle levels: all pins high, released line reads high
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h1f;

  localparam logic [`SWLI_ADDR_BITS-1:0] ADDR_ZERO = 3'h0;

  swli_link_if link ();  // Link between shifter and control

  logic [SYNC_W-1:0]         syncIn;          // Raw crossing lanes
  logic [SYNC_W-1:0]         syncOut;         // Settled lanes
  logic                      csSyncN;         // Settled select, low active
  logic                      prSyncN;         // Settled preset, low active
  logic                      pdSyncN;         // Settled power-down
  logic                      sdoSync;         // Settled displaced bit

  logic                      csPrev_ff;       // Select one cycle ago
  logic                      prPrev_ff;       // Preset one cycle ago
  logic                      csRise;          // Frame just ended
  logic                      csFall;          // Frame just began
  logic                      prRise;          // Preset just released

  swli_pkg::swli_state_type  state_ff;        // Frame tracker
  swli_pkg::swli_state_type  nxt_state;       // Its next value
  logic                      spoiled_ff;      // Frame hit by preset/power-down
  swli_pkg::swli_word_type   capWord_ff;      // Word held at frame end
  logic [`SWLI_ADDR_BITS-1:0] capAddr;        // Channel select field
  swli_pkg::swli_wiper_type  capData;         // Setting field
  logic [NUM_CH-1:0]         loadStrobe;      // One-hot channel strobe
  logic                      doLoad;          // Commit a word this cycle

  swli_pkg::swli_wiper_type  wiper_ff [NUM_CH];  // Setting latches
  logic                      nxt_sdoOe;          // Next line enable

  ////////////////////////////////////////////////////////////////////////
  // Link-side shifter

  // Select and data are launched by the host against serialClk, so
  // the shifter samples them directly in that domain
  assign link.chipSelectN  = chipSelectN;
  assign link.serialDataIn = serialDataIn;

  swli_shifter uShifter (
    .serialClk (serialClk),
    .link      (link)
  );

  ////////////////////////////////////////////////////////////////////////
  // Crossing into the system clock domain

  // Pins and the displaced bit are asynchronous to clk
  assign syncIn[LANE_PD]  = powerDownN;
  assign syncIn[LANE_PR]  = midscalePresetN;
  assign syncIn[LANE_CS]  = chipSelectN;
  assign syncIn[LANE_SDO] = link.sdoBit;
  assign syncIn[LANE_PIN] = serialDataOutIn;

  swli_sync #(
    .WIDTH   (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) uSync (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn (syncIn),
    .syncOut (syncOut)
  );

  assign pdSyncN = syncOut[LANE_PD];
  assign prSyncN = syncOut[LANE_PR];
  assign csSyncN = syncOut[LANE_CS];
  assign sdoSync = syncOut[LANE_SDO];

  ////////////////////////////////////////////////////////////////////////
  // Edge detection on settled levels

  // Previous levels start idle so reset release fakes no edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      csPrev_ff <= 1'h1;
      prPrev_ff <= 1'h1;
    end else begin
      csPrev_ff <= csSyncN;
      prPrev_ff <= prSyncN;
    end
  end

  assign csRise = csSyncN & ~csPrev_ff;
  assign csFall = ~csSyncN & csPrev_ff;
  assign prRise = prSyncN & ~prPrev_ff;

  ////////////////////////////////////////////////////////////////////////
  // Frame tracking

  // Next state from the select edges
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      swli_pkg::SWLI_IDLE: begin
        // Clock and data while deselected do nothing
        if (csFall) begin
          nxt_state = swli_pkg::SWLI_FRAME;
        end
      end
      swli_pkg::SWLI_FRAME: begin
        // Any count of bits may arrive; only the end matters
        if (csRise) begin
          nxt_state = swli_pkg::SWLI_LOAD;
        end
      end
      swli_pkg::SWLI_LOAD: begin
        // Single commit cycle, then back to waiting
        nxt_state = csSyncN ? swli_pkg::SWLI_IDLE : swli_pkg::SWLI_FRAME;
      end
      default: begin
        nxt_state = swli_pkg::SWLI_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= swli_pkg::SWLI_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Shifting counts only while preset and power-down are both
  // inactive; the shifter cannot see them without a running clock,
  // so a frame touched by either is discarded at its end instead
  always_ff @(posedge clk) begin
    if (!resetn) begin
      spoiled_ff <= 1'h0;
    end else if (csFall) begin
      spoiled_ff <= ~prSyncN | ~pdSyncN;
    end else if (state_ff == swli_pkg::SWLI_FRAME) begin
      if (!prSyncN || !pdSyncN) begin
        spoiled_ff <= 1'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Word capture

  // The shift register is frozen while deselected, and the settled
  // select edge arrives two clk cycles after the select rise, itself after the last shift, so the
  // word is stable when sampled here
  always_ff @(posedge clk) begin
    if (!resetn) begin
      capWord_ff <= '0;
    end else if (state_ff == swli_pkg::SWLI_FRAME && csRise) begin
      // Last eleven bits only; earlier chained bits fell out
      capWord_ff <= link.shiftWord;
    end
  end

  // Field split: address on top, setting below, both MSB-first
  assign capAddr = capWord_ff[`SWLI_ADDR_LSB +: `SWLI_ADDR_BITS];
  assign capData = capWord_ff[`SWLI_DATA_LSB +: `SWLI_DATA_BITS];

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  // Commit only a clean frame, and only after the select rose
  assign doLoad = (state_ff == swli_pkg::SWLI_LOAD) & ~spoiled_ff;

  // Address n selects channel n+1; codes NUM_CH and up match nothing
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : gDecode
    localparam logic [`SWLI_ADDR_BITS-1:0] CH_ADDR = ADDR_ZERO + 3'(ch);
    assign loadStrobe[ch] = doLoad & (capAddr == CH_ADDR);
  end

  ////////////////////////////////////////////////////////////////////////
  // Wiper setting latches

  // Priority: reset, held preset, preset release, then serial load.
  // Power-down never touches these, so settings survive it.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        wiper_ff[i] <= `SWLI_MIDSCALE;
      end
    end else if (!prSyncN) begin
      // Held preset overrides clock and select alike
      for (int i = 0; i < NUM_CH; i++) begin
        wiper_ff[i] <= `SWLI_MIDSCALE;
      end
    end else if (prRise && csSyncN) begin
      for (int i = 0; i < NUM_CH; i++) begin
        wiper_ff[i] <= `SWLI_MIDSCALE;
      end
    end else begin
      // At most one strobe is high; the rest keep their value
      for (int i = 0; i < NUM_CH; i++) begin
        if (loadStrobe[i]) begin
          wiper_ff[i] <= capData;
        end
      end
    end
  end

  // Flatten the latches onto the output bus, channel 1 lowest
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wiperSetting_ff <= {NUM_CH{`SWLI_MIDSCALE}};
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        wiperSetting_ff[i*`SWLI_DATA_BITS +: `SWLI_DATA_BITS] <= wiper_ff[i];
      end
    end
  end

  // Per-channel update pulse, one cycle, one cycle ahead of the new
  // value on the flattened output bus
  always_ff @(posedge clk) begin
    if (!resetn) begin
      channelLoad_ff <= '0;
    end else begin
      channelLoad_ff <= loadStrobe & {NUM_CH{prSyncN}};
    end
  end

  // Frame ended without any update: spoiled or unmapped address
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wordDropped_ff <= 1'h0;
    end else begin
      wordDropped_ff <= (state_ff == swli_pkg::SWLI_LOAD)
                        & (spoiled_ff | ~|loadStrobe);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-down of the resistor network

  // Active only with preset released; latches are left alone
  always_ff @(posedge clk) begin
    if (!resetn) begin
      aTerminalOpen_ff <= 1'h0;
      wiperToB_ff      <= 1'h0;
    end else begin
      aTerminalOpen_ff <= ~pdSyncN & prSyncN;
      wiperToB_ff      <= ~pdSyncN & prSyncN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Open-drain serial output

  // Line enable: preset clears the output latch (line low), power-down
  // releases the line, and a selected frame passes the displaced bit.
  // The displaced bit crosses through two flops, so chained parts need
  // a serial clock well below the clk rate.
  always_comb begin
    if (!prSyncN) begin
      nxt_sdoOe = 1'h1;
    end else if (!pdSyncN) begin
      nxt_sdoOe = 1'h0;
    end else if (!csSyncN) begin
      nxt_sdoOe = ~sdoSync;
    end else begin
      nxt_sdoOe = 1'h0;
    end
  end

  // Drive low only; a one is the released line pulled high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      serialDataOut_ff   <= 1'h0;
      serialDataOutOe_ff <= 1'h0;
    end else begin
      serialDataOut_ff   <= 1'h0;
      serialDataOutOe_ff <= nxt_sdoOe;
    end
  end

  // Settled level seen on the shared line, for contention checks
  always_ff @(posedge clk) begin
    if (!resetn) begin
      serialOutLevel_ff <= 1'h1;
    end else begin
      serialOutLevel_ff <= syncOut[LANE_PIN];
    end
  end

endmodule

/* sim/swli_top_sva.sv */
`timescale 1ns/1ps
`include "swli_defs.svh"

////////////////////////////////////////
// Port-level checks beside each wiper latch block
module swli_top_sva #(
  parameter int NUM_CH = `SWLI_NUM_CH  // Four or six channels
) (
  input wire logic                              clk,
  input wire logic                              resetn,
  input wire logic                              serialClk,
  input wire logic                              chipSelectN,
  input wire logic                              serialDataIn,
  input wire logic                              midscalePresetN,
  input wire logic                              powerDownN,
  input wire logic                              serialDataOutIn,
  input wire logic                              serialDataOut_ff,
  input wire logic                              serialDataOutOe_ff,
  input wire logic                              serialOutLevel_ff,
  input wire logic [NUM_CH*`SWLI_DATA_BITS-1:0] wiperSetting_ff,
  input wire logic [NUM_CH-1:0]                 channelLoad_ff,
  input wire logic                              wordDropped_ff,
  input wire logic                              aTerminalOpen_ff,
  input wire logic                              wiperToB_ff
);
  logic [3:0] csHighCnt_ff;   // Cycles since select went high
  logic [3:0] presetHighCnt_ff; // Cycles since preset released

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Saturating so a long idle never wraps into the load window
  always_ff @(posedge clk) begin
    if (!resetn || !chipSelectN) begin
      csHighCnt_ff <= 4'h0;
    end else if (csHighCnt_ff != 4'hf) begin
      csHighCnt_ff <= csHighCnt_ff + 4'h1;
    end
  end

  // Preset settle count; preset reloads are excluded from load checks
  always_ff @(posedge clk) begin
    if (!resetn || !midscalePresetN) begin
      presetHighCnt_ff <= 4'h0;
    end else if (presetHighCnt_ff != 4'hf) begin
      presetHighCnt_ff <= presetHighCnt_ff + 4'h1;
    end
  end

  a_out_low: assert property (serialDataOut_ff == 1'b0)
    else $error("serial output value not low");
  a_one_load: assert property ($onehot0(channelLoad_ff) && !(wordDropped_ff && |channelLoad_ff))
    else $error("more than one latch strobed");
  // The flattened bus changes one cycle after the load pulse
  a_others_keep: assert property (!$past(|channelLoad_ff) && presetHighCnt_ff > 4'h8 |->
    $stable(wiperSetting_ff))
    else $error("latch changed without load");
  a_load_timing: assert property (|channelLoad_ff && presetHighCnt_ff > 4'h8 |->
    csHighCnt_ff inside {[4'h2:4'h7]})
    else $error("load not tied to select rise");
  a_frame_ends: assert property ($rose(chipSelectN) && presetHighCnt_ff > 4'h8 |->
    ##[2:9] (wordDropped_ff || |channelLoad_ff))
    else $error("frame end gave no outcome");
  a_preset_mid: assert property ((!midscalePresetN && powerDownN) [*5] |->
    wiperSetting_ff == {NUM_CH{`SWLI_MIDSCALE}} && serialDataOutOe_ff && channelLoad_ff == '0)
    else $error("preset did not centre wipers");
  a_pdown_on: assert property ((!powerDownN && midscalePresetN) [*5] |->
    aTerminalOpen_ff && wiperToB_ff && !serialDataOutOe_ff)
    else $error("power-down outputs wrong");
  a_pdown_off: assert property (powerDownN [*5] |-> !aTerminalOpen_ff && !wiperToB_ff)
    else $error("power-down outputs stuck");
  a_idle_release: assert property ((chipSelectN && midscalePresetN) [*5] |-> !serialDataOutOe_ff)
    else $error("serial line driven while idle");
  a_reset_mid: assert property (@(posedge clk) disable iff (1'b0) !resetn |=>
    wiperSetting_ff == {NUM_CH{`SWLI_MIDSCALE}} && channelLoad_ff == '0)
    else $error("reset did not centre wipers");

  c_load: cover property (channelLoad_ff[0]);
  c_drop: cover property (wordDropped_ff);
  c_pdown: cover property (aTerminalOpen_ff);
endmodule

bind swli_top swli_top_sva #(.NUM_CH(NUM_CH)) swli_top_sva_inst (
  .clk(clk), .resetn(resetn), .serialClk(serialClk), .chipSelectN(chipSelectN),
  .serialDataIn(serialDataIn), .midscalePresetN(midscalePresetN), .powerDownN(powerDownN),
  .serialDataOutIn(serialDataOutIn), .serialDataOut_ff(serialDataOut_ff),
  .serialDataOutOe_ff(serialDataOutOe_ff), .serialOutLevel_ff(serialOutLevel_ff),
  .wiperSetting_ff(wiperSetting_ff), .channelLoad_ff(channelLoad_ff), .wordDropped_ff(wordDropped_ff),
  .aTerminalOpen_ff(aTerminalOpen_ff), .wiperToB_ff(wiperToB_ff));

/* sim/swli_host_model.sv */
`timescale 1ns/1ps

////////////////////////////////////////
// Host on the three-wire serial input; clock still outside frames
module swli_host_model (
  input  wire logic clk,
  output logic      serialClk,
  output logic      chipSelectN,
  output logic      serialDataIn
);
  int pause = 0;  // Extra ns per bit for a slow host

  // Idle: deselected, clock low
  initial begin
    serialClk = 1'b0;
    chipSelectN = 1'b1;
    serialDataIn = 1'b0;
  end

  // Open a frame and let the select settle in the system domain
  task automatic csLow();
    @(negedge clk);
    chipSelectN = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // Address then data, MSB first, 64 ns bit period
  task automatic sendWord(input swli_pkg::swli_word_type w);
    for (int i = 10; i >= 0; i--) begin
      serialDataIn = w[i];
      #(32 + pause) serialClk = 1'b1;
      #32 serialClk = 1'b0;
    end
  endtask

  // Close only after the whole chain is shifted; data then goes stale
  task automatic csHigh();
    repeat (4) @(negedge clk);
    chipSelectN = 1'b1;
    serialDataIn = ~serialDataIn;
  endtask
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
`include "swli_defs.svh"

////////////////////////////////////////
// Four- and six-channel blocks side by side on one host
module testbench;
  logic                    clk = 1'b0;    // System clock
  logic                    resetn = 1'b0; // Sync reset
  logic                    presetN = 1'b1; // Midscale preset drive
  logic                    pdN = 1'b1;    // Power-down drive
  logic                    sck, csN, sdi; // Host serial lines
  logic                    oe4, oe6, lvl4, dr4, dr6, ato, wtb;
  logic                    line4, line6;  // Pulled-up open-drain lines
  logic [31:0]             w4;            // Four-channel settings
  logic [47:0]             w6;            // Six-channel settings
  logic                    drop4, drop6;  // Sticky drop pulses
  swli_pkg::swli_wiper_type e4 [4];       // Expected settings
  swli_pkg::swli_wiper_type e6 [6];
  int                      nTests = 0;
  int                      nMismatch = 0;
  int                      cycles = 0;

  assign line4 = oe4 ? 1'b0 : 1'b1;
  assign line6 = oe6 ? 1'b0 : 1'b1;

  always #50 clk = ~clk;

  swli_host_model host_inst (.clk(clk), .serialClk(sck), .chipSelectN(csN), .serialDataIn(sdi));

  swli_top #(.NUM_CH(4)) swli_top_inst (.clk(clk), .resetn(resetn), .serialClk(sck), .chipSelectN(csN),
    .serialDataIn(sdi), .midscalePresetN(presetN), .powerDownN(pdN), .serialDataOutIn(line4),
    .serialDataOut_ff(), .serialDataOutOe_ff(oe4), .serialOutLevel_ff(lvl4), .wiperSetting_ff(w4),
    .channelLoad_ff(), .wordDropped_ff(dr4), .aTerminalOpen_ff(ato), .wiperToB_ff(wtb));

  // Six-channel variant, same stimulus
  swli_top #(.NUM_CH(6)) swli_top_6_inst (.clk(clk), .resetn(resetn), .serialClk(sck), .chipSelectN(csN),
    .serialDataIn(sdi), .midscalePresetN(presetN), .powerDownN(pdN), .serialDataOutIn(line6),
    .serialDataOut_ff(), .serialDataOutOe_ff(oe6), .serialOutLevel_ff(), .wiperSetting_ff(w6),
    .channelLoad_ff(), .wordDropped_ff(dr6), .aTerminalOpen_ff(), .wiperToB_ff());

  // Catch one-cycle drop pulses; cleared by the bench off the edge
  always @(posedge clk) begin
    if (dr4) drop4 <= 1'b1;
    if (dr6) drop6 <= 1'b1;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      nMismatch++;
      results();
    end
  end

  task automatic checkByte(input swli_pkg::swli_wiper_type got, input swli_pkg::swli_wiper_type exp,
                           input string what);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp, input string what);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // Every channel of both blocks against the model
  task automatic checkAll();
    for (int k = 0; k < 4; k++) checkByte(w4[8*k +: 8], e4[k], "four-ch setting");
    for (int k = 0; k < 6; k++) checkByte(w6[8*k +: 8], e6[k], "six-ch setting");
  endtask

  task automatic centre();
    for (int k = 0; k < 6; k++) e6[k] = `SWLI_MIDSCALE;
    for (int k = 0; k < 4; k++) e4[k] = `SWLI_MIDSCALE;
  endtask

  // One frame, one word; refused when shut down, preset or unmapped
  task automatic wr(input logic [2:0] a, input swli_pkg::swli_wiper_type d);
    logic ok;
    ok = presetN && pdN;
    drop4 = 1'b0;
    drop6 = 1'b0;
    host_inst.csLow();
    host_inst.sendWord({a, d});
    host_inst.csHigh();
    repeat (10) @(negedge clk);
    if (a < 3'h4 && ok) e4[a[1:0]] = d;
    if (a < 3'h6 && ok) e6[a] = d;
    checkBit(drop4, !(a < 3'h4 && ok), "four-ch drop");
    checkBit(drop6, !(a < 3'h6 && ok), "six-ch drop");
    checkAll();
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    swli_pkg::swli_wiper_type d;
    centre();
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    checkAll();
    checkBit(ato, 1'b0, "A open at rest");
    // Every address, then boundary codes and a slow host
    for (int a = 0; a < 8; a++) wr(a[2:0], 8'(8'h21 * a + 8'h0e));
    wr(3'h0, 8'hff);
    wr(3'h1, 8'h00);
    host_inst.pause = 200;
    wr(3'h2, 8'h5a);
    host_inst.pause = 0;
    // Two words in one frame: first leaves by the serial output
    for (int b = 0; b < 2; b++) begin
      d = b ? 8'h3a : 8'hc5;
      host_inst.csLow();
      host_inst.sendWord({3'h0, 7'h2a, b[0]});
      host_inst.sendWord({3'h3, d});
      repeat (8) @(negedge clk);
      checkBit(oe4, !b[0], "out drive");
      checkBit(lvl4, b[0], "out level");
      host_inst.csHigh();
      repeat (10) @(negedge clk);
      e4[3] = d;
      e6[3] = d;
      checkAll();
    end
    // Preset forces centre; frames refused meanwhile
    presetN = 1'b0;
    repeat (6) @(negedge clk);
    centre();
    checkAll();
    checkBit(oe4, 1'b1, "preset out latch");
    // Low bit zero: it is the displaced bit of the next frame
    wr(3'h1, 8'h76);
    presetN = 1'b1;
    repeat (6) @(negedge clk);
    checkAll();
    // Power-down keeps settings and releases the line
    wr(3'h1, 8'h9e);
    pdN = 1'b0;
    repeat (6) @(negedge clk);
    checkBit(ato, 1'b1, "A open");
    checkBit(wtb, 1'b1, "wiper to B");
    checkBit(lvl4, 1'b1, "line released");
    // Selected with a zero waiting: the line would be pulled low
    host_inst.csLow();
    checkBit(oe4, 1'b0, "line off in frame");
    host_inst.csHigh();
    repeat (10) @(negedge clk);
    wr(3'h1, 8'h33);
    pdN = 1'b1;
    repeat (6) @(negedge clk);
    checkBit(ato, 1'b0, "A closed");
    checkAll();
    // Reset again in mid-run
    resetn = 1'b0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    centre();
    repeat (3) @(negedge clk);
    checkAll();
    results();
  end
endmodule
